// ===== hdl/pin_mux_pkg.sv
package pin_mux_pkg;

	// Register indexes; the byte address on the bus is four times the index.
	localparam int unsigned         ADDR_W           = 12;
	localparam logic [7:0]          IDX_MEM_CFG_ONE  = 8'h66;
	localparam logic [7:0]          IDX_MISC_SIX     = 8'h70;
	localparam logic [7:0]          IDX_FUNC_EN_ONE  = 8'hB0;
	localparam logic [7:0]          IDX_FUNC_EN_TWO  = 8'hB1;
	localparam logic [7:0]          IDX_MISC_THREE   = 8'hBA;

	// Values after reset select the default pin functions.
	localparam logic [7:0]          RST_MEM_CFG_ONE  = 8'h00;
	localparam logic [7:0]          RST_MISC_SIX     = 8'h00;
	localparam logic [7:0]          RST_FUNC_EN_ONE  = 8'h00;
	localparam logic [7:0]          RST_FUNC_EN_TWO  = 8'h00;
	localparam logic [7:0]          RST_MISC_THREE   = 8'h00;
	localparam logic [1:0]          RST_STRAP        = 2'h0;

	// Field positions.
	localparam int unsigned         BUS_OPT_LSB      = 5;
	localparam logic [7:0]          MEM_CFG_WR_MASK  = 8'h9F;
	localparam int unsigned         SRAM_SEL_BIT     = 0;
	localparam int unsigned         PPORT_MODE_LSB   = 0;
	localparam int unsigned         OSC_EN_BIT       = 2;
	localparam int unsigned         BAUD_EN_BIT      = 0;
	localparam int unsigned         AUTOFEED_CLK_BIT = 3;

	// Strap codes, upper strap in bit 1.
	localparam logic [1:0]          STRAP_LOCAL_BUS  = 2'h2;
	localparam logic [1:0]          STRAP_MAX_ISA    = 2'h3;

	// Parallel port modes.
	typedef enum logic [1:0] {
		PPORT_UNIDIR = 2'h0,
		PPORT_BIDIR  = 2'h1,
		PPORT_EPP    = 2'h2,
		PPORT_RSVD   = 2'h3
	} pport_mode_t;

	// Synchroniser depth for pin inputs.
	localparam int unsigned         SYNC_STAGES      = 2;

endpackage : pin_mux_pkg

// ===== hdl/pin_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a group of pin inputs. Only the second stage
// leaves the module, so no logic can look at the metastable first stage.
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Pins in and synchronised copies out.
	input  wire logic [WIDTH-1:0]  pin_in,
	output logic      [WIDTH-1:0]  pin_sync_out
);

	logic [WIDTH-1:0] stage1_q;

	// First stage feeds the second stage only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_q     <= '0;
			pin_sync_out <= '0;
		end else begin
			stage1_q     <= pin_in;
			pin_sync_out <= stage1_q;
		end
	end

endmodule : pin_sync

// ===== hdl/strap_capture.sv
`timescale 1ns/1ps
// Holds the bus option straps. The value follows the straps while a capturing
// reset is asserted, so what stands at its rising edge is what is kept.
module strap_capture (
	// Clock and power-up reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Synchronised reset pin levels, high when released.
	input  wire logic       proc_rst_rel,
	input  wire logic       io_rst_rel,
	// Synchronised strap levels.
	input  wire logic [1:0] strap_level,
	// Captured option and pin direction.
	output logic      [1:0] strap_q,
	output logic            strap_drive_en
);

	logic power_done_q;
	logic capture;

	// After the first release only the processor reset recaptures.
	assign capture = !proc_rst_rel || (!io_rst_rel && !power_done_q);

	// Power-up flag, cleared only by the power-on reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_done_q <= 1'b0;
		end else if (proc_rst_rel && io_rst_rel) begin
			power_done_q <= 1'b1;
		end
	end

	// Captured strap value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_q <= pin_mux_pkg::RST_STRAP;
		end else if (capture) begin
			strap_q <= strap_level;
		end
	end

	// Straps are inputs until both resets have been released.
	assign strap_drive_en = proc_rst_rel && io_rst_rel;

endmodule : strap_capture

// ===== hdl/bus_option_strap_pin_mux.sv
`timescale 1ns/1ps
module bus_option_strap_pin_mux (
	// APB slave.
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [pin_mux_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// Reset pins, low when asserted.
	input  wire logic                            processor_reset_in_n,
	input  wire logic                            io_side_reset_n,
	// Strap pins shared with the serial port outputs.
	input  wire logic                            strap_select_high_in,
	output logic                                 strap_select_high_out,
	output logic                                 strap_select_high_oe_n,
	input  wire logic                            strap_select_low_in,
	output logic                                 strap_select_low_out,
	output logic                                 strap_select_low_oe_n,
	input  wire logic                            serial_dtr,
	input  wire logic                            serial_rts,
	// Core side of the local bus and ISA functions.
	input  wire logic [23:12]                    local_addr_hi,
	input  wire logic [23:17]                    isa_unlatched_addr,
	input  wire logic                            isa_bale,
	input  wire logic [3:0]                      dma_ack,
	input  wire logic                            core_ready,
	input  wire logic                            low_meg_decode,
	input  wire logic [3:0]                      local_ctrl,
	input  wire logic                            local_upper_byte_en,
	input  wire logic                            local_lower_byte_en,
	input  wire logic                            local_addr_strobe,
	output logic                                 max_isa_mode,
	output logic                                 local_ready_in,
	output logic      [3:0]                      dma_req,
	output logic      [4:0]                      irq_req,
	output logic                                 zero_wait_req,
	// Shared bus pins.
	output logic      [23:12]                    addr_pin,
	output logic                                 local_ready_out,
	input  wire logic [3:0]                      ctrl_pin_in,
	output logic      [3:0]                      ctrl_pin_out,
	output logic      [3:0]                      ctrl_pin_oe_n,
	input  wire logic [4:0]                      irq_pin_in,
	output logic      [4:0]                      irq_pin_out,
	output logic      [4:0]                      irq_pin_oe_n,
	input  wire logic                            strobe_pin_in,
	output logic                                 strobe_pin_out,
	output logic                                 strobe_pin_oe_n,
	// Memory strobes.
	input  wire logic [3:0]                      col_strobe,
	input  wire logic [3:0]                      sram_select,
	output logic      [3:0]                      mem_strobe_pin,
	// Parallel port.
	input  wire logic                            pport_data_write_enable,
	input  wire logic                            pport_data_decode,
	output logic                                 pport_wr_pin,
	input  wire logic                            pport_autofeed,
	output logic                                 pport_autofeed_pin,
	// Clock sources and the clock output pin.
	input  wire logic                            osc_14m_clk,
	input  wire logic                            baud_clk,
	output logic                                 osc_clock_out,
	output logic                                 osc_clock_oe_n
);

	localparam int unsigned SYNC_W = 14;

	logic [7:0]        mem_cfg_one_q;
	logic [7:0]        misc_six_q;
	logic [7:0]        func_en_one_q;
	logic [7:0]        func_en_two_q;
	logic [7:0]        misc_three_q;
	logic [31:0]       prdata_q;
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_s;
	logic [1:0]        strap_q;
	logic              strap_drive_en;
	logic              is_isa;
	logic              sram_mode;
	logic              pport_swap;
	logic              osc_en;
	logic              baud_en;
	logic              addr_ok;
	logic [7:0]        cur_idx;
	logic              wr_access;

	// Word index of an address, low byte lanes dropped.
	function automatic logic [7:0] reg_index(input logic [pin_mux_pkg::ADDR_W-1:0] a);
		reg_index = a[9:2];
	endfunction : reg_index

	// Whether an index names a register of this block.
	function automatic logic idx_mapped(input logic [pin_mux_pkg::ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		idx_mapped = (a[11:10] == 2'h0) && (a[1:0] == 2'h0) &&
			((i == pin_mux_pkg::IDX_MEM_CFG_ONE) || (i == pin_mux_pkg::IDX_MISC_SIX) ||
			 (i == pin_mux_pkg::IDX_FUNC_EN_ONE) || (i == pin_mux_pkg::IDX_FUNC_EN_TWO) ||
			 (i == pin_mux_pkg::IDX_MISC_THREE));
	endfunction : idx_mapped

	// All pin inputs cross into pclk before any logic reads them.
	assign pins_raw = {processor_reset_in_n, io_side_reset_n,
		strap_select_high_in, strap_select_low_in,
		strobe_pin_in, irq_pin_in, ctrl_pin_in};

	pin_sync #(
		.WIDTH        (SYNC_W)
	) u_pin_sync (
		.pclk         (pclk),
		.presetn      (presetn),
		.pin_in       (pins_raw),
		.pin_sync_out (pins_s)
	);

	strap_capture u_strap_capture (
		.pclk           (pclk),
		.presetn        (presetn),
		.proc_rst_rel   (pins_s[13]),
		.io_rst_rel     (pins_s[12]),
		.strap_level    (pins_s[11:10]),
		.strap_q        (strap_q),
		.strap_drive_en (strap_drive_en)
	);

	// Only the documented all-high code selects ISA; anything else keeps the
	// local bus, which is the safer choice for a mis-strapped board.
	assign is_isa       = (strap_q == pin_mux_pkg::STRAP_MAX_ISA);
	assign max_isa_mode = is_isa;

	// Strap pins float while reset holds them as inputs.
	assign strap_select_high_out  = serial_dtr;
	assign strap_select_low_out   = serial_rts;
	assign strap_select_high_oe_n = !strap_drive_en;
	assign strap_select_low_oe_n  = !strap_drive_en;

	// Decoded firmware controls.
	assign sram_mode  = misc_six_q[pin_mux_pkg::SRAM_SEL_BIT];
	assign pport_swap = (func_en_one_q[pin_mux_pkg::PPORT_MODE_LSB +: 2] == 2'h1) ||
		(func_en_one_q[pin_mux_pkg::PPORT_MODE_LSB +: 2] == 2'h2);
	assign osc_en     = func_en_one_q[pin_mux_pkg::OSC_EN_BIT];
	assign baud_en    = func_en_two_q[pin_mux_pkg::BAUD_EN_BIT];

	// APB decode. The slave never waits; read data is taken in the setup cycle.
	assign cur_idx   = reg_index(paddr);
	assign addr_ok   = idx_mapped(paddr);
	assign wr_access = psel && penable && pwrite && addr_ok;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !addr_ok;
	assign prdata    = prdata_q;

	// Read data register, loaded at the setup edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata_q <= 32'h0000_0000;
			if (addr_ok) begin
				case (cur_idx)
					pin_mux_pkg::IDX_MEM_CFG_ONE: begin
						prdata_q[7:0] <= (mem_cfg_one_q & pin_mux_pkg::MEM_CFG_WR_MASK) |
							{1'b0, strap_q, 5'h00};
					end
					pin_mux_pkg::IDX_MISC_SIX:    prdata_q[7:0] <= misc_six_q;
					pin_mux_pkg::IDX_FUNC_EN_ONE: prdata_q[7:0] <= func_en_one_q;
					pin_mux_pkg::IDX_FUNC_EN_TWO: prdata_q[7:0] <= func_en_two_q;
					pin_mux_pkg::IDX_MISC_THREE:  prdata_q[7:0] <= misc_three_q;
					default:                      prdata_q[7:0] <= 8'h00;
				endcase
			end
		end
	end

	// Memory configuration; the bus option field is read-only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_cfg_one_q <= pin_mux_pkg::RST_MEM_CFG_ONE;
		end else if (wr_access && (cur_idx == pin_mux_pkg::IDX_MEM_CFG_ONE)) begin
			mem_cfg_one_q <= pwdata[7:0] & pin_mux_pkg::MEM_CFG_WR_MASK;
		end
	end

	// Firmware pin function registers, written by software only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc_six_q    <= pin_mux_pkg::RST_MISC_SIX;
			func_en_one_q <= pin_mux_pkg::RST_FUNC_EN_ONE;
			func_en_two_q <= pin_mux_pkg::RST_FUNC_EN_TWO;
			misc_three_q  <= pin_mux_pkg::RST_MISC_THREE;
		end else if (wr_access) begin
			case (cur_idx)
				pin_mux_pkg::IDX_MISC_SIX:    misc_six_q    <= pwdata[7:0];
				pin_mux_pkg::IDX_FUNC_EN_ONE: func_en_one_q <= pwdata[7:0];
				pin_mux_pkg::IDX_FUNC_EN_TWO: func_en_two_q <= pwdata[7:0];
				pin_mux_pkg::IDX_MISC_THREE:  misc_three_q  <= pwdata[7:0];
				default: begin
					misc_six_q <= misc_six_q;
				end
			endcase
		end
	end

	// Address pins: local address, or ISA latch enable, acks and high address.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_pin <= 12'h000;
		end else if (is_isa) begin
			addr_pin[12]    <= isa_bale;
			addr_pin[13]    <= dma_ack[2];
			addr_pin[14]    <= dma_ack[3];
			addr_pin[15]    <= dma_ack[1];
			addr_pin[16]    <= dma_ack[0];
			addr_pin[23:17] <= isa_unlatched_addr;
		end else begin
			addr_pin <= local_addr_hi;
		end
	end

	// Ready pin carries the low-meg decode in ISA mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			local_ready_out <= 1'b0;
		end else begin
			local_ready_out <= is_isa ? low_meg_decode : core_ready;
		end
	end

	// Control, byte-enable and strobe pin directions. Order of the control
	// group is data/control, memory/IO, ready, write/read.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_pin_out    <= 4'h0;
			ctrl_pin_oe_n   <= 4'hF;
			irq_pin_out     <= 5'h00;
			irq_pin_oe_n    <= 5'h1F;
			strobe_pin_out  <= 1'b0;
			strobe_pin_oe_n <= 1'b1;
		end else begin
			ctrl_pin_out    <= {local_ctrl[3], 1'b0, local_ctrl[1:0]};
			ctrl_pin_oe_n   <= is_isa ? 4'hF : 4'h4;
			irq_pin_out     <= {3'h0, local_lower_byte_en, local_upper_byte_en};
			irq_pin_oe_n    <= is_isa ? 5'h1F : 5'h1C;
			strobe_pin_out  <= local_addr_strobe;
			strobe_pin_oe_n <= is_isa;
		end
	end

	// Inputs gained in ISA mode read zero in local bus mode; local_ready_in is the reverse and reads zero in ISA mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_req        <= 4'h0;
			irq_req        <= 5'h00;
			zero_wait_req  <= 1'b0;
			local_ready_in <= 1'b0;
		end else begin
			dma_req        <= is_isa ? pins_s[3:0] : 4'h0;
			irq_req        <= is_isa ? pins_s[8:4] : 5'h00;
			zero_wait_req  <= is_isa && pins_s[9];
			local_ready_in <= !is_isa && pins_s[2];
		end
	end

	// Memory strobes: DRAM column strobes or SRAM chip selects.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_strobe_pin <= 4'hF;
		end else begin
			mem_strobe_pin <= sram_mode ? sram_select : col_strobe;
		end
	end

	// Parallel port write enable pin.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pport_wr_pin <= 1'b1;
		end else begin
			pport_wr_pin <= pport_swap ? pport_data_decode : pport_data_write_enable;
		end
	end

	// Clock outputs are gated combinationally: a flop on pclk cannot carry
	// a 14 MHz or baud clock. Selects change only from software writes, so
	// a glitch can occur only at the moment software switches the source.
	assign osc_clock_out      = baud_en ? baud_clk : (osc_en && osc_14m_clk);
	assign osc_clock_oe_n     = !(baud_en || osc_en);
	assign pport_autofeed_pin = misc_three_q[pin_mux_pkg::AUTOFEED_CLK_BIT] ? osc_14m_clk :
		pport_autofeed;

endmodule : bus_option_strap_pin_mux

// ===== verification/pin_mux_sva.sv
`timescale 1ns/1ps
// Watches the pin multiplexer at its ports. Firmware bits are shadowed from
// APB writes, so the memory strobe, parallel port write and clock enable pin choices can be predicted without looking inside.
module pin_mux_sva (
	// Clock, reset and APB.
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	// Reset and strap pins.
	input wire logic        processor_reset_in_n,
	input wire logic        io_side_reset_n,
	input wire logic        strap_select_high_in,
	input wire logic        strap_select_low_in,
	input wire logic        strap_select_high_oe_n,
	// Bus option pins.
	input wire logic        max_isa_mode,
	input wire logic        isa_bale,
	input wire logic [3:0]  dma_ack,
	input wire logic [23:12] addr_pin,
	input wire logic [3:0]  dma_req,
	input wire logic [4:0]  irq_req,
	// Firmware selected pins.
	input wire logic [3:0]  col_strobe,
	input wire logic [3:0]  sram_select,
	input wire logic [3:0]  mem_strobe_pin,
	input wire logic        pport_data_write_enable,
	input wire logic        pport_data_decode,
	input wire logic        pport_wr_pin,
	input wire logic        osc_clock_oe_n
);
	logic       wr_en, mapped, straps_isa, sram_q, osc_q, baud_q, wr_exp;
	logic [1:0] pmode_q;
	logic [3:0] mem_exp;
	logic [4:0] isa_low;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Decodes and expected pin sources; the memory strobe and parallel port sources are worked out from the shadow bits.
	assign wr_en = psel && penable && pwrite;
	assign mapped = paddr inside {12'h198, 12'h1C0, 12'h2C0, 12'h2C4, 12'h2E8};
	assign straps_isa = strap_select_high_in && strap_select_low_in;
	assign mem_exp = sram_q ? sram_select : col_strobe;
	assign wr_exp = (pmode_q == 2'h1 || pmode_q == 2'h2) ? pport_data_decode : pport_data_write_enable;
	assign isa_low = {dma_ack[0], dma_ack[1], dma_ack[3], dma_ack[2], isa_bale};

	// Shadow copies land at the access edge, the same edge as the design's.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sram_q  <= 1'b0;
			pmode_q <= 2'h0;
			osc_q   <= 1'b0;
			baud_q  <= 1'b0;
		end else if (wr_en) begin
			if (paddr == 12'h1C0) sram_q <= pwdata[0];
			if (paddr == 12'h2C0) pmode_q <= pwdata[1:0];
			if (paddr == 12'h2C0) osc_q <= pwdata[2];
			if (paddr == 12'h2C4) baud_q <= pwdata[0];
		end
	end

	// Capture window closes once the processor reset has been high a while.
	sequence proc_release;
		$rose(processor_reset_in_n) && io_side_reset_n;
	endsequence
	sequence proc_high_run;
		processor_reset_in_n [*5];
	endsequence

	apb_error_a: assert property (psel && penable |-> pslverr == !mapped)
		else $error("error response does not match address decode");
	mem_pins_a: assert property ($past(presetn) |-> mem_strobe_pin == $past(mem_exp))
		else $error("memory strobe pins carry the wrong source");
	pport_pin_a: assert property ($past(presetn) |-> pport_wr_pin == $past(wr_exp))
		else $error("parallel port pin carries the wrong source");
	osc_float_a: assert property (osc_clock_oe_n == !(osc_q || baud_q))
		else $error("clock pin enable does not follow its selects");
	strap_float_a: assert property (!processor_reset_in_n || !io_side_reset_n |-> ##2 strap_select_high_oe_n)
		else $error("strap pin driven during reset");
	strap_drive_a: assert property ((processor_reset_in_n && io_side_reset_n) [*4] |-> !strap_select_high_oe_n)
		else $error("strap pin not driven after reset");
	local_quiet_a: assert property ($past(presetn) && !$past(max_isa_mode) |-> dma_req == 4'h0 && irq_req == 5'h00)
		else $error("request inputs active in local bus mode");
	isa_addr_a: assert property ($past(presetn) && $past(max_isa_mode) |-> addr_pin[16:12] == $past(isa_low))
		else $error("latch enable or acknowledges on wrong address pins");
	io_hold_a: assert property (proc_high_run |=> $stable(max_isa_mode))
		else $error("bus option changed without processor reset");
	proc_capture_a: assert property (proc_release |-> ##4 max_isa_mode == $past(straps_isa, 4))
		else $error("bus option does not match straps at release");
endmodule : pin_mux_sva

bind bus_option_strap_pin_mux pin_mux_sva u_pin_mux_sva (.*);

// ===== verification/board_straps.sv
`timescale 1ns/1ps
// Board side of the two strap pins. Resistors set the level whenever the
// device leaves a pin undriven; the device's output wins otherwise.
module board_straps (
	// Option chosen by the board build.
	input  wire logic isa_sel,
	// Device side of the strap pins.
	input  wire logic high_out,
	input  wire logic high_oe_n,
	input  wire logic low_out,
	input  wire logic low_oe_n,
	// Resolved pin levels.
	output logic      high_pin,
	output logic      low_pin
);
	// Upper strap is pulled high in both builds, lower to the chosen option.
	assign high_pin = high_oe_n ? 1'b1 : high_out;
	assign low_pin  = low_oe_n ? isa_sel : low_out;
endmodule : board_straps

// ===== verification/bus_option_strap_pin_mux_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end
// Drives the multiplexer through APB, the reset pins and the board straps.
module bus_option_strap_pin_mux_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, isa_sel;
	logic [pin_mux_pkg::ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        processor_reset_in_n, io_side_reset_n, serial_dtr, serial_rts;
	logic        strap_select_high_in, strap_select_high_out, strap_select_high_oe_n;
	logic        strap_select_low_in, strap_select_low_out, strap_select_low_oe_n;
	logic [23:12] local_addr_hi, addr_pin;
	logic [23:17] isa_unlatched_addr;
	logic        isa_bale, core_ready, low_meg_decode, local_upper_byte_en, local_lower_byte_en;
	logic        local_addr_strobe, max_isa_mode, local_ready_in, zero_wait_req, local_ready_out;
	logic [3:0]  dma_ack, local_ctrl, dma_req, ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe_n;
	logic [3:0]  col_strobe, sram_select, mem_strobe_pin;
	logic [4:0]  irq_req, irq_pin_in, irq_pin_out, irq_pin_oe_n;
	logic        strobe_pin_in, strobe_pin_out, strobe_pin_oe_n;
	logic        pport_data_write_enable, pport_data_decode, pport_wr_pin, pport_autofeed;
	logic        pport_autofeed_pin, osc_14m_clk, baud_clk, osc_clock_out, osc_clock_oe_n;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cyc = 0;

	bus_option_strap_pin_mux u_bus_option_strap_pin_mux (.*);
	board_straps u_board_straps (
		.isa_sel   (isa_sel),
		.high_out  (strap_select_high_out),
		.high_oe_n (strap_select_high_oe_n),
		.low_out   (strap_select_low_out),
		.low_oe_n  (strap_select_low_oe_n),
		.high_pin  (strap_select_high_in),
		.low_pin   (strap_select_low_in)
	);

	// Clock at 40 MHz.
	always #12.5 pclk = ~pclk;

	// Cuts a hung run short; the sequence needs well under this many cycles.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	// One APB transfer, held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input logic exp_err);
		apb(1'b0, a, 32'h0);
		`CHK(rd, {24'h0, exp})
		`CHK(err, exp_err)
	endtask : rd_chk

	// Pin outputs lag through synchronisers and one register; give them time.
	task automatic settle();
		repeat (6) @(posedge pclk);
		#1;
	endtask : settle

	// Power-up in local bus build, then firmware choices, then a switch to ISA.
	initial begin
		{pclk, presetn, psel, penable, pwrite, processor_reset_in_n, io_side_reset_n, isa_sel} = '0;
		{paddr, pwdata, serial_dtr, serial_rts} = {12'h0, 32'h0, 2'b10};
		{local_addr_hi, isa_unlatched_addr, isa_bale, dma_ack, core_ready, low_meg_decode, local_ctrl} = '0;
		{local_upper_byte_en, local_lower_byte_en, local_addr_strobe, ctrl_pin_in, irq_pin_in, strobe_pin_in} = '0;
		{col_strobe, sram_select, pport_data_write_enable, pport_data_decode, pport_autofeed} = '0;
		{osc_14m_clk, baud_clk} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		`CHK(strap_select_high_oe_n, 1'b1)
		@(posedge pclk);
		processor_reset_in_n <= 1'b1;
		io_side_reset_n      <= 1'b1;
		settle();
		`CHK({strap_select_high_oe_n, strap_select_low_oe_n}, 2'b00)
		`CHK({strap_select_high_out, strap_select_low_out}, {serial_dtr, serial_rts})
		`CHK(max_isa_mode, 1'b0)
		rd_chk(12'h198, 8'h40, 1'b0);
		rd_chk(12'h1C0, 8'h00, 1'b0);
		rd_chk(12'h2C0, 8'h00, 1'b0);
		rd_chk(12'h2C4, 8'h00, 1'b0);
		rd_chk(12'h2E8, 8'h00, 1'b0);
		rd_chk(12'h004, 8'h00, 1'b1);
		`CHK(pready, 1'b1)
		@(posedge pclk);
		{col_strobe, sram_select, pport_data_write_enable, pport_data_decode} <= {4'h5, 4'hA, 2'b10};
		{local_addr_hi, ctrl_pin_in, core_ready} <= {12'hA5C, 4'h4, 1'b1};
		{local_ctrl, local_upper_byte_en, local_lower_byte_en, local_addr_strobe} <= {4'h9, 3'b101};
		settle();
		`CHK({mem_strobe_pin, pport_wr_pin}, {col_strobe, pport_data_write_enable})
		`CHK(osc_clock_oe_n, 1'b1)
		`CHK({addr_pin, local_ready_out}, {local_addr_hi, core_ready})
		`CHK({ctrl_pin_oe_n, irq_pin_oe_n, strobe_pin_oe_n, local_ready_in}, {4'h4, 5'h1C, 2'b01})
		`CHK({ctrl_pin_out[3], ctrl_pin_out[1:0], irq_pin_out[1:0]}, 5'h15)
		`CHK(strobe_pin_out, local_addr_strobe)
		apb(1'b1, 12'h1C0, 32'h1);
		settle();
		`CHK(mem_strobe_pin, sram_select)
		apb(1'b1, 12'h198, 32'hFFFF_FFFF);
		rd_chk(12'h198, 8'hDF, 1'b0);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 12'h2C0, 32'(m));
			settle();
			`CHK(pport_wr_pin, (m == 1 || m == 2) ? pport_data_decode : pport_data_write_enable)
		end
		@(posedge pclk);
		{osc_14m_clk, baud_clk, pport_autofeed} <= 3'b100;
		apb(1'b1, 12'h2C0, 32'h4);
		settle();
		`CHK({osc_clock_oe_n, osc_clock_out}, {1'b0, osc_14m_clk})
		apb(1'b1, 12'h2C4, 32'h1);
		settle();
		`CHK({osc_clock_oe_n, osc_clock_out}, {1'b0, baud_clk})
		apb(1'b1, 12'h2E8, 32'h8);
		settle();
		`CHK(pport_autofeed_pin, osc_14m_clk)
		apb(1'b1, 12'h2E8, 32'h0);
		apb(1'b1, 12'h2C0, 32'h0);
		apb(1'b1, 12'h2C4, 32'h0);
		settle();
		`CHK({osc_clock_oe_n, pport_autofeed_pin}, {1'b1, pport_autofeed})
		@(posedge pclk);
		isa_sel         <= 1'b1;
		io_side_reset_n <= 1'b0;
		repeat (8) @(posedge pclk);
		io_side_reset_n <= 1'b1;
		settle();
		`CHK(max_isa_mode, 1'b0)
		@(posedge pclk);
		processor_reset_in_n <= 1'b0;
		repeat (8) @(posedge pclk);
		processor_reset_in_n <= 1'b1;
		settle();
		`CHK(max_isa_mode, 1'b1)
		rd_chk(12'h198, 8'hFF, 1'b0);
		rd_chk(12'h1C0, 8'h01, 1'b0);
		@(posedge pclk);
		{isa_bale, dma_ack, isa_unlatched_addr, low_meg_decode} <= {1'b1, 4'b0110, 7'h55, 1'b0};
		{ctrl_pin_in, irq_pin_in, strobe_pin_in} <= {4'hB, 5'h16, 1'b1};
		settle();
		`CHK(addr_pin, {7'h55, 5'b01011})
		`CHK({dma_req, irq_req, zero_wait_req, local_ready_in}, {4'hB, 5'h16, 2'b10})
		`CHK({ctrl_pin_oe_n, irq_pin_oe_n, strobe_pin_oe_n}, {4'hF, 5'h1F, 1'b1})
		`CHK({local_ready_out, mem_strobe_pin}, {low_meg_decode, sram_select})
		close_out();
	end
endmodule : bus_option_strap_pin_mux_tb
